// ===== hdl/block_ram_pkg.sv
// Shared constants and types for the embedded block RAM port logic
package block_ram_pkg;
  // Core geometry: depth and widest word of one block
  localparam int ADDR_WIDTH = 9;
  localparam int DATA_WIDTH = 36;
  localparam int DEPTH = 512;
  localparam int SELECT_WIDTH = 3;

  // Reset value of the read latches and of the output pipeline stage
  localparam logic [DATA_WIDTH-1:0] READ_RESET_VALUE = 36'h0_0000_0000;

  // reset_timing_select encodings
  localparam logic RESET_SYNC = 1'b0;
  localparam logic RESET_ASYNC = 1'b1;

  // output_pipeline_select encodings
  localparam logic UNREGISTERED_OUTPUT = 1'b0;
  localparam logic REGISTERED_OUTPUT = 1'b1;

  // Supported word widths
  typedef enum logic [2:0] {
    WIDTH_X1,
    WIDTH_X2,
    WIDTH_X4,
    WIDTH_X9,
    WIDTH_X18,
    WIDTH_X36
  } word_width_type;

  // Read output behaviour during a write cycle
  typedef enum logic [1:0] {
    HOLD_OUTPUT,
    PASS_NEW_DATA,
    PASS_OLD_DATA
  } write_output_type;

  // Bits of the 36-bit core that a word of the given width occupies
  function automatic logic [DATA_WIDTH-1:0] widthMask(input word_width_type width);
    logic [DATA_WIDTH-1:0] mask;
    mask = 36'h0_0000_0000;
    case (width)
      WIDTH_X1: mask = 36'h0_0000_0001;
      WIDTH_X2: mask = 36'h0_0000_0003;
      WIDTH_X4: mask = 36'h0_0000_000F;
      WIDTH_X9: mask = 36'h0_0000_01FF;
      WIDTH_X18: mask = 36'h0_0003_FFFF;
      WIDTH_X36: mask = 36'hF_FFFF_FFFF;
      default: mask = 36'h0_0000_0000;
    endcase
    return mask;
  endfunction

  // Old-data passing exists only for the parity-capable widths
  function automatic logic oldDataCapable(input word_width_type width);
    return (width == WIDTH_X9) || (width == WIDTH_X18) || (width == WIDTH_X36);
  endfunction
endpackage

// ===== hdl/embedded_ram_block.sv
// Dual-port embedded RAM block with select decode, write-output modes and pipeline option
`timescale 1ns/1ps

// What this block does
// RULE_01 - Words stored and read are exactly as wide as the chosen word width.
// RULE_02 - Read data comes straight out, or through an extra register when enabled.
// RULE_03 - With synchronous reset timing, memory reset acts only at a clock edge.
// RULE_04 - With asynchronous reset timing, memory reset clears outputs at once.
// RULE_05 - When cascading, outside logic drives chip selects from the top address bits.
// RULE_06 - Each port has a three-bit chip select, allowing eight cascaded blocks.
// RULE_07 - A port acts only when its chip select equals its three-bit match value.
// RULE_08 - Pseudo dual-port mode uses separate match values for write and read ports.
// RULE_09 - True dual-port mode gives ports A and B independent match values.
// RULE_10 - Hold mode keeps the read output unchanged during a write.
// RULE_11 - New-data mode shows the written word on the read output.
// RULE_12 - Old-data mode shows the previous contents; only at widths 9, 18, 36.
// RULE_13 - In true dual-port mode each port picks its own write-output behaviour.
// RULE_14 - Outside logic avoids reading an address the other port is writing.
// RULE_15 - Outside logic avoids writing one address from both ports together.
// RULE_16 - Outside logic should detect same-address collisions and flag or block them.
// RULE_17 - An option decides whether chip-wide global set/reset clears this block.
// RULE_18 - A write whose chip select does not match leaves memory untouched.
module embedded_ram_block (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic memReset,
  input wire logic globalSetReset,
  input wire logic globalSetResetEnable,
  input wire block_ram_pkg::word_width_type wordWidth,
  input wire logic outputPipelineSelect,
  input wire logic resetTimingSelect,
  input wire logic trueDualPort,
  input wire logic [block_ram_pkg::SELECT_WIDTH-1:0] portASelectMatch,
  input wire logic [block_ram_pkg::SELECT_WIDTH-1:0] portBSelectMatch,
  input wire block_ram_pkg::write_output_type portAWriteOutputBehaviour,
  input wire block_ram_pkg::write_output_type portBWriteOutputBehaviour,
  input wire logic portAEnable,
  input wire logic [block_ram_pkg::SELECT_WIDTH-1:0] portAChipSelect,
  input wire logic portAWriteEnable,
  input wire logic [block_ram_pkg::ADDR_WIDTH-1:0] portAAddress,
  input wire logic [block_ram_pkg::DATA_WIDTH-1:0] portAWriteData,
  output logic [block_ram_pkg::DATA_WIDTH-1:0] portAReadData,
  input wire logic portBEnable,
  input wire logic [block_ram_pkg::SELECT_WIDTH-1:0] portBChipSelect,
  input wire logic portBWriteEnable,
  input wire logic [block_ram_pkg::ADDR_WIDTH-1:0] portBAddress,
  input wire logic [block_ram_pkg::DATA_WIDTH-1:0] portBWriteData,
  output logic [block_ram_pkg::DATA_WIDTH-1:0] portBReadData
);
  import block_ram_pkg::*;

  logic [DATA_WIDTH-1:0] mem [DEPTH];
  logic [DATA_WIDTH-1:0] mask;
  logic asyncClear;
  logic syncClear;
  logic enable [2];
  logic [SELECT_WIDTH-1:0] chipSelect [2];
  logic [SELECT_WIDTH-1:0] selectMatch [2];
  logic writeEnable [2];
  logic [ADDR_WIDTH-1:0] address [2];
  logic [DATA_WIDTH-1:0] writeData [2];
  write_output_type behaviour [2];
  logic hit [2];
  logic writeAllowed [2];
  logic readAllowed [2];
  logic [DATA_WIDTH-1:0] storedWord [2];
  logic [DATA_WIDTH-1:0] coreData [2];
  logic [DATA_WIDTH-1:0] next_coreData [2];
  logic [DATA_WIDTH-1:0] pipeData [2];
  logic [DATA_WIDTH-1:0] next_pipeData [2];
  logic [DATA_WIDTH-1:0] readData [2];

  ////////////////////////////////////////////////////////////////////////////
  // Port bundling: A is also the write port and B the read port in pseudo mode
  assign enable[0] = portAEnable;
  assign enable[1] = portBEnable;
  assign chipSelect[0] = portAChipSelect; // RULE_06
  assign chipSelect[1] = portBChipSelect; // RULE_06
  assign selectMatch[0] = portASelectMatch; // RULE_08
  assign selectMatch[1] = portBSelectMatch; // RULE_09
  assign writeEnable[0] = portAWriteEnable;
  assign writeEnable[1] = portBWriteEnable;
  assign address[0] = portAAddress;
  assign address[1] = portBAddress;
  assign writeData[0] = portAWriteData;
  assign writeData[1] = portBWriteData;
  assign behaviour[0] = portAWriteOutputBehaviour; // RULE_13
  assign behaviour[1] = portBWriteOutputBehaviour; // RULE_13
  assign portAReadData = readData[0];
  assign portBReadData = readData[1];

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources. The async path is a decoded reset, so memReset and
  // globalSetReset must be glitch-free register outputs in the fabric.
  assign mask = widthMask(wordWidth); // RULE_01
  assign asyncClear = sys_rst
                      || (resetTimingSelect == RESET_ASYNC && memReset) // RULE_04
                      || (globalSetResetEnable && globalSetReset); // RULE_17
  assign syncClear = (resetTimingSelect == RESET_SYNC) && memReset; // RULE_03

  ////////////////////////////////////////////////////////////////////////////
  // Memory array: no reset, contents survive every reset source.
  // Port B is applied last; equal-address double writes are the user's hazard.
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (writeAllowed[p]) begin // RULE_18
        mem[address[p]] <= writeData[p] & mask; // RULE_01
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_port
      // Decode: in pseudo mode port B never writes and port A never reads
      always_comb begin
        hit[g] = enable[g] && (chipSelect[g] == selectMatch[g]); // RULE_07
        writeAllowed[g] = hit[g] && writeEnable[g] && (g == 0 || trueDualPort);
        readAllowed[g] = hit[g] && !writeAllowed[g] && (g == 1 || trueDualPort);
        storedWord[g] = mem[address[g]] & mask;
      end

      // Read latch and pipeline stage next values
      always_comb begin
        next_coreData[g] = coreData[g];
        if (syncClear) begin
          next_coreData[g] = READ_RESET_VALUE; // RULE_03
        end else if (writeAllowed[g]) begin
          unique case (behaviour[g])
            HOLD_OUTPUT: next_coreData[g] = coreData[g]; // RULE_10
            PASS_NEW_DATA: next_coreData[g] = writeData[g] & mask; // RULE_11
            PASS_OLD_DATA: begin
              // Narrow widths lack the old-data path and fall back to hold
              if (oldDataCapable(wordWidth)) begin
                next_coreData[g] = storedWord[g]; // RULE_12
              end
            end
            default: next_coreData[g] = coreData[g];
          endcase
        end else if (readAllowed[g]) begin
          next_coreData[g] = storedWord[g];
        end
        next_pipeData[g] = syncClear ? READ_RESET_VALUE : coreData[g];
      end

      // Registers share the combined asynchronous clear
      always_ff @(posedge clk or posedge asyncClear) begin
        if (asyncClear) begin
          coreData[g] <= READ_RESET_VALUE; // RULE_04
          pipeData[g] <= READ_RESET_VALUE;
        end else begin
          coreData[g] <= next_coreData[g];
          pipeData[g] <= next_pipeData[g];
        end
      end

      // Registered output costs one cycle of latency for better timing
      assign readData[g] = (outputPipelineSelect == REGISTERED_OUTPUT) ?
                           pipeData[g] : coreData[g]; // RULE_02

      ////////////////////////////////////////////////////////////////////////
      // Checks
      a_width_mask: assert property (@(posedge clk) disable iff (asyncClear) // RULE_01
        ##1 (readData[g] & ~mask) == 36'h0_0000_0000 || $changed(wordWidth))
        else $error("read data wider than word width");
      a_pipe_delay: assert property (@(posedge clk) disable iff (asyncClear) // RULE_02
        (outputPipelineSelect && !syncClear) |=> pipeData[g] == $past(coreData[g]))
        else $error("pipeline stage does not lag read latch by one cycle");
      a_sync_reset: assert property (@(posedge clk) disable iff (asyncClear) // RULE_03
        syncClear |=> coreData[g] == READ_RESET_VALUE && pipeData[g] == READ_RESET_VALUE)
        else $error("synchronous memory reset did not clear outputs");
      a_async_reset: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
        (resetTimingSelect == RESET_ASYNC && memReset) |-> coreData[g] == READ_RESET_VALUE)
        else $error("asynchronous memory reset did not clear output");
      a_gsr_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE_17
        (globalSetResetEnable && globalSetReset) |-> pipeData[g] == READ_RESET_VALUE)
        else $error("enabled global set/reset did not clear output");
      a_hold_write: assert property (@(posedge clk) disable iff (asyncClear) // RULE_10
        (writeAllowed[g] && behaviour[g] == HOLD_OUTPUT && !syncClear) |=> $stable(coreData[g]))
        else $error("hold mode changed read output during write");
      a_new_data: assert property (@(posedge clk) disable iff (asyncClear) // RULE_11
        (writeAllowed[g] && behaviour[g] == PASS_NEW_DATA && !syncClear)
        |=> coreData[g] == ($past(writeData[g]) & $past(mask)))
        else $error("write-through output does not show written word");
      a_old_data: assert property (@(posedge clk) disable iff (asyncClear) // RULE_12
        (writeAllowed[g] && behaviour[g] == PASS_OLD_DATA && !syncClear
         && oldDataCapable(wordWidth)) |=> coreData[g] == $past(storedWord[g]))
        else $error("old-data mode does not show previous contents");
      // Unwritten words start unknown, so the word is compared exactly, unknowns included
      a_select_miss: assert property (@(posedge clk) disable iff (asyncClear) // RULE_18
        (enable[g] && writeEnable[g] && chipSelect[g] != selectMatch[g]
         && !writeAllowed[1-g])
        |=> mem[$past(address[g])] === $past(mem[address[g]]))
        else $error("memory changed on a write with mismatched chip select");
      a_select_hit: assert property (@(posedge clk) disable iff (asyncClear) // RULE_07
        (enable[g] && writeEnable[g] && chipSelect[g] != selectMatch[g]) |-> !writeAllowed[g])
        else $error("write accepted with mismatched chip select");
    end
  endgenerate

  // Main scenarios
  c_write_through: cover property (@(posedge clk) disable iff (asyncClear)
    writeAllowed[0] && behaviour[0] == PASS_NEW_DATA ##1 outputPipelineSelect);
  c_old_data_b: cover property (@(posedge clk) disable iff (asyncClear)
    trueDualPort && writeAllowed[1] && behaviour[1] == PASS_OLD_DATA);
  c_pseudo_pair: cover property (@(posedge clk) disable iff (asyncClear)
    !trueDualPort && writeAllowed[0] ##1 readAllowed[1]);
  c_cascade_miss: cover property (@(posedge clk) disable iff (asyncClear)
    enable[0] && writeEnable[0] && !hit[0]);
endmodule

// ===== verification/fabric_port_driver.sv
// Fabric-side model that drives both RAM ports, one access at a time
`timescale 1ns/1ps
module fabric_port_driver (
  input wire logic clk,
  output logic [1:0] enable,
  output logic [1:0][2:0] chipSelect,
  output logic [1:0] writeEnable,
  output logic [1:0][8:0] address,
  output logic [1:0][35:0] writeData
);
  // Idle state at time zero
  initial begin
    enable = 2'h0;
    chipSelect = 6'h00;
    writeEnable = 2'h0;
    address = 18'h00000;
    writeData = 72'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Accesses are serialised, so the ports never collide on one address
  task automatic op(input int p, input logic we, input logic [11:0] fa,
                    input logic [35:0] d);
    @(negedge clk);
    enable[p] = 1'h1;
    chipSelect[p] = fa[11:9];
    writeEnable[p] = we;
    address[p] = fa[8:0];
    writeData[p] = d;
    @(negedge clk);
    // Released address and data lines show the inverse so a stale value never looks valid
    enable[p] = 1'h0;
    address[p] = ~fa[8:0];
    writeData[p] = ~d;
  endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench comparing the RAM block with a behavioural model
`timescale 1ns/1ps
module tb_top;
  import block_ram_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic memReset = 1'h0;
  logic globalSetReset = 1'h0;
  logic globalSetResetEnable = 1'h0;
  word_width_type wordWidth = WIDTH_X36;
  logic outputPipelineSelect = 1'h0;
  logic resetTimingSelect = 1'h0;
  logic trueDualPort = 1'h1;
  logic [2:0] portASelectMatch = 3'h5;
  logic [2:0] portBSelectMatch = 3'h2;
  write_output_type portAWriteOutputBehaviour = HOLD_OUTPUT;
  write_output_type portBWriteOutputBehaviour = HOLD_OUTPUT;
  logic [1:0] en, we;
  logic [1:0][2:0] cs;
  logic [1:0][8:0] ad;
  logic [1:0][35:0] wd;
  logic [35:0] portAReadData, portBReadData;
  logic [35:0] mem [512];
  logic [35:0] expOut [2] = '{36'h0, 36'h0};
  logic [31:0] seed = 32'h12;
  int bw [6] = '{1, 2, 4, 9, 18, 36};
  int error_cnt = 0;
  int n_checks = 0;
  logic [8:0] a;

  always #5 clk = ~clk;

  fabric_port_driver drv (.clk(clk), .enable(en), .chipSelect(cs), .writeEnable(we),
    .address(ad), .writeData(wd));

  embedded_ram_block DUT (.clk(clk), .sys_rst(sys_rst), .memReset(memReset),
    .globalSetReset(globalSetReset), .globalSetResetEnable(globalSetResetEnable),
    .wordWidth(wordWidth), .outputPipelineSelect(outputPipelineSelect),
    .resetTimingSelect(resetTimingSelect), .trueDualPort(trueDualPort),
    .portASelectMatch(portASelectMatch), .portBSelectMatch(portBSelectMatch),
    .portAWriteOutputBehaviour(portAWriteOutputBehaviour),
    .portBWriteOutputBehaviour(portBWriteOutputBehaviour),
    .portAEnable(en[0]), .portAChipSelect(cs[0]), .portAWriteEnable(we[0]),
    .portAAddress(ad[0]), .portAWriteData(wd[0]), .portAReadData(portAReadData),
    .portBEnable(en[1]), .portBChipSelect(cs[1]), .portBWriteEnable(we[1]),
    .portBAddress(ad[1]), .portBWriteData(wd[1]), .portBReadData(portBReadData));

  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift source, widened to a full word
  function automatic logic [35:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {seed[3:0], seed};
  endfunction

  // One comparison, counted; mismatches reported at once
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    n_checks++;
    if (seen !== want || $isunknown(seen)) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // One access: model update, drive, then compare after the read latency
  task automatic go(input int p, input logic w, input logic [11:0] fa, input logic [35:0] d);
    logic [35:0] m, old, prev;
    logic hit;
    write_output_type md;
    m = (36'h1 << bw[wordWidth]) - 36'h1;
    md = p ? portBWriteOutputBehaviour : portAWriteOutputBehaviour;
    hit = (fa[11:9] == (p ? portBSelectMatch : portASelectMatch)) && (trueDualPort || w == (p == 0));
    old = mem[fa[8:0]];
    prev = expOut[p];
    if (hit && w) mem[fa[8:0]] = d & m;
    if (hit && !w) expOut[p] = old & m;
    else if (hit && md == PASS_NEW_DATA) expOut[p] = d & m;
    else if (hit && md == PASS_OLD_DATA && wordWidth >= WIDTH_X9) expOut[p] = old & m;
    drv.op(p, w, fa, d);
    if (outputPipelineSelect) begin
      check(p ? portBReadData : portAReadData, prev);
      @(negedge clk);
    end
    check(p ? portBReadData : portAReadData, expOut[p]);
  endtask

  // Memory or global reset pulse; async clears at once, sync waits for an edge
  task automatic clr(input logic g);
    @(negedge clk);
    if (g) globalSetReset = 1'h1;
    else memReset = 1'h1;
    #1;
    check(portAReadData, (resetTimingSelect || g) ? 36'h0 : expOut[0]);
    @(negedge clk);
    check(portBReadData, 36'h0);
    memReset = 1'h0;
    globalSetReset = 1'h0;
    expOut[0] = 36'h0;
    expOut[1] = 36'h0;
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: decode, widths and modes in both pipeline settings, resets, pseudo mode
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    for (int i = 0; i < 8; i++) go(0, 1'h1, {i[2:0], 9'h010}, rnd());
    go(1, 1'h0, {3'h2, 9'h010}, 36'h0);
    for (int q = 0; q < 2; q++) begin
      outputPipelineSelect = q[0];
      for (int w = 0; w < 6; w++) begin
        resetTimingSelect = w[0];
        clr(1'h0);
        wordWidth = word_width_type'(w);
        a = 9'(rnd());
        for (int k = 0; k < 3; k++) begin
          portAWriteOutputBehaviour = write_output_type'(k);
          portBWriteOutputBehaviour = write_output_type'(2 - k);
          go(0, 1'h1, {3'h5, a}, rnd());
          go(1, 1'h1, {3'h2, a}, rnd());
          go(1, 1'h0, {3'h2, a}, 36'h0);
        end
      end
    end
    // Global set/reset must do nothing while its option is off
    globalSetReset = 1'h1;
    repeat (2) @(negedge clk);
    check(portBReadData, expOut[1]);
    globalSetReset = 1'h0;
    globalSetResetEnable = 1'h1;
    clr(1'h1);
    trueDualPort = 1'h0;
    // The first pseudo write hits a word never written, so old-data output would be unknown
    portAWriteOutputBehaviour = PASS_NEW_DATA;
    portASelectMatch = 3'h1;
    portBSelectMatch = 3'h6;
    go(0, 1'h1, 12'h244, rnd());
    go(1, 1'h0, 12'hC44, 36'h0);
    go(0, 1'h1, 12'hC44, rnd());
    go(1, 1'h0, 12'h244, 36'h0);
    go(1, 1'h0, 12'hC44, 36'h0);
    close_out();
  end

  // Watchdog against a hung run
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
endmodule
